// [src/eep_select_prog_ctrl.sv]
`timescale 1ns/1ps
module eep_select_prog_ctrl #(
    parameter int WORD_CYCLES = eep_pkg::WORD_CYCLES,
    parameter int ARRAY_ERASE_CYCLES = eep_pkg::ARRAY_ERASE_CYCLES,
    parameter int ARRAY_WRITE_CYCLES = eep_pkg::ARRAY_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic select_line,
    input wire logic serial_in_pin,
    input wire logic power_good,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic standby,
    output logic busy
);
    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    eep_pkg::eep_link_state_t lk_state_r;
    eep_pkg::eep_cmd_t cmd_r;
    eep_pkg::eep_cmd_t issue_cmd;
    logic req_tog_r, ack_tog_r, rd_bit_r, rd_act_r, lk_started_r;
    logic [5:0] sy1_r, sy2_r;
    logic sel_s, pwr_s, req_s, rd_bit_s, rd_act_s, started_s;
    logic [eep_pkg::DATA_W-1:0] mem_r [eep_pkg::WORDS];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1_r <= 6'h00;
            sy2_r <= 6'h00;
        end else begin
            sy1_r <= {lk_started_r, select_line, power_good, req_tog_r, rd_bit_r, rd_act_r};
            sy2_r <= sy1_r;
        end
    end
    assign started_s = sy2_r[5];
    assign sel_s = sy2_r[4];
    assign pwr_s = sy2_r[3];
    assign req_s = sy2_r[2];
    assign rd_bit_s = sy2_r[1];
    assign rd_act_s = sy2_r[0];

    // ----------------------------------------------------------------
    // Link side: start, header, data and read shifting
    // ----------------------------------------------------------------
    logic link_arst_n, ack_l1_r, ack_l2_r, bsy_l1_r, bsy_l2_r;
    logic [4:0] bit_cnt_r;
    logic [eep_pkg::HDR_BITS-1:0] hdr_r, hdr_nxt;
    logic [eep_pkg::DATA_W-1:0] data_r, data_nxt, rd_sh_r;
    logic [eep_pkg::ADDR_W-1:0] rd_addr_r;
    logic issue_req, issue;

    assign link_arst_n = select_line & rst_n;
    assign hdr_nxt = {hdr_r[eep_pkg::HDR_BITS-2:0], serial_in_pin};
    assign data_nxt = {data_r[eep_pkg::DATA_W-2:0], serial_in_pin};

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_l1_r <= 1'b0;
            ack_l2_r <= 1'b0;
            bsy_l1_r <= 1'b0;
            bsy_l2_r <= 1'b0;
        end else begin
            ack_l1_r <= ack_tog_r;
            ack_l2_r <= ack_l1_r;
            bsy_l1_r <= busy;
            bsy_l2_r <= bsy_l1_r;
        end
    end

    always_comb begin
        issue_req = 1'b0;
        issue_cmd = '0;
        issue_cmd.addr = hdr_nxt[eep_pkg::ADDR_W-1:0];
        if (lk_state_r == eep_pkg::LK_HDR && bit_cnt_r == 5'(eep_pkg::HDR_BITS - 1)) begin
            case (hdr_nxt[7:6])
                eep_pkg::OP_ERASE: begin
                    issue_req = 1'b1;
                    issue_cmd.kind = eep_pkg::CMD_ERASE;
                end
                eep_pkg::OP_EXT: begin
                    issue_req = (hdr_nxt[5:4] != eep_pkg::EXT_WRITE_WHOLE_ARRAY);
                    case (hdr_nxt[5:4])
                        eep_pkg::EXT_LOCK: issue_cmd.kind = eep_pkg::CMD_LOCK;
                        eep_pkg::EXT_UNLOCK: issue_cmd.kind = eep_pkg::CMD_UNLOCK;
                        default: issue_cmd.kind = eep_pkg::CMD_ERASE_WHOLE_ARRAY;
                    endcase
                end
                default: issue_req = 1'b0;
            endcase
        end else if (lk_state_r == eep_pkg::LK_DATA
                     && bit_cnt_r == 5'(eep_pkg::DATA_W - 1)) begin
            issue_req = 1'b1;
            issue_cmd.addr = hdr_r[eep_pkg::ADDR_W-1:0];
            issue_cmd.data = data_nxt;
            issue_cmd.kind = (hdr_r[7:6] == eep_pkg::OP_WRITE) ? eep_pkg::CMD_WRITE
                                                               : eep_pkg::CMD_WRITE_WHOLE_ARRAY;
        end
    end
    // A command still waiting for its acknowledge blocks a new one
    assign issue = issue_req && (ack_l2_r == req_tog_r);

    // Held across deselection so the crossing is never torn
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_tog_r <= 1'b0;
            cmd_r <= '0;
        end else if (issue) begin
            req_tog_r <= ~req_tog_r;
            cmd_r <= issue_cmd;
        end
    end

    always_ff @(posedge link_clk or negedge link_arst_n) begin
        if (!link_arst_n) begin
            lk_state_r <= eep_pkg::LK_WAIT;
            bit_cnt_r <= 5'h00;
            hdr_r <= '0;
            data_r <= '0;
            rd_sh_r <= '0;
            rd_addr_r <= '0;
            rd_bit_r <= 1'b0;
            rd_act_r <= 1'b0;
            lk_started_r <= 1'b0;
        end else begin
            case (lk_state_r)
                eep_pkg::LK_WAIT: begin
                    if (serial_in_pin) begin
                        lk_state_r <= eep_pkg::LK_HDR;
                        lk_started_r <= 1'b1;
                        bit_cnt_r <= 5'h00;
                    end
                end
                eep_pkg::LK_HDR: begin
                    hdr_r <= hdr_nxt;
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (bit_cnt_r == 5'(eep_pkg::HDR_BITS - 1)) begin
                        bit_cnt_r <= 5'h00;
                        if (hdr_nxt[7:6] == eep_pkg::OP_READ) begin
                            // Array only moves while programming, so it is stable here
                            rd_sh_r <= bsy_l2_r ? '0 : mem_r[hdr_nxt[5:0]];
                            rd_addr_r <= hdr_nxt[5:0] + 6'h01;
                            rd_bit_r <= 1'b0;
                            rd_act_r <= 1'b1;
                            lk_state_r <= eep_pkg::LK_READ;
                        end else if (hdr_nxt[7:6] == eep_pkg::OP_WRITE
                                     || hdr_nxt[7:4] == {eep_pkg::OP_EXT, eep_pkg::EXT_WRITE_WHOLE_ARRAY}) begin
                            lk_state_r <= eep_pkg::LK_DATA;
                        end else begin
                            lk_state_r <= eep_pkg::LK_DONE;
                        end
                    end
                end
                eep_pkg::LK_DATA: begin
                    data_r <= data_nxt;
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (bit_cnt_r == 5'(eep_pkg::DATA_W - 1)) begin
                        lk_state_r <= eep_pkg::LK_DONE;
                    end
                end
                eep_pkg::LK_READ: begin
                    rd_bit_r <= rd_sh_r[eep_pkg::DATA_W-1];
                    rd_sh_r <= {rd_sh_r[eep_pkg::DATA_W-2:0], 1'b0};
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                    if (bit_cnt_r == 5'(eep_pkg::DATA_W - 1)) begin
                        // Sequential read rolls to the next word
                        bit_cnt_r <= 5'h00;
                        rd_sh_r <= bsy_l2_r ? '0 : mem_r[rd_addr_r];
                        rd_addr_r <= rd_addr_r + 6'h01;
                    end
                end
                eep_pkg::LK_DONE: lk_state_r <= eep_pkg::LK_DONE;
                default: lk_state_r <= eep_pkg::LK_WAIT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Two-entry command buffer
    // ----------------------------------------------------------------
    eep_pkg::eep_cmd_t buf_r [eep_pkg::BUF_DEPTH];
    eep_pkg::eep_cmd_t pop_cmd;
    logic [0:0] wptr_r, rptr_r;
    logic [1:0] count_r;
    logic push_valid, push_ready, pop_valid, pop_ready;

    assign push_valid = (req_s != ack_tog_r);
    assign push_ready = (count_r != 2'(eep_pkg::BUF_DEPTH));
    assign pop_valid = (count_r != 2'h0);
    assign pop_cmd = buf_r[rptr_r];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            count_r <= 2'h0;
            ack_tog_r <= 1'b0;
        end else begin
            if (push_valid && push_ready) begin
                buf_r[wptr_r] <= cmd_r;
                wptr_r <= wptr_r + 1'b1;
                ack_tog_r <= ~ack_tog_r;
            end
            if (pop_valid && pop_ready) begin
                rptr_r <= rptr_r + 1'b1;
            end
            count_r <= count_r + 2'(push_valid && push_ready) - 2'(pop_valid && pop_ready);
        end
    end

    // ----------------------------------------------------------------
    // Self-timed erase and write engine
    // ----------------------------------------------------------------
    localparam int CNT_W = eep_pkg::CNT_W;
    eep_pkg::eep_exec_state_t ex_state_r;
    logic [eep_pkg::CNT_W-1:0] cnt_r;
    logic [eep_pkg::ADDR_W-1:0] tgt_addr_r;
    logic [eep_pkg::DATA_W-1:0] tgt_data_r, wr_val;
    logic lock_r, wr_one, wr_all, cnt_zero, is_prog;

    assign pop_ready = (ex_state_r == eep_pkg::EX_IDLE);
    assign cnt_zero = (cnt_r == '0);
    assign is_prog = (pop_cmd.kind != eep_pkg::CMD_LOCK) && (pop_cmd.kind != eep_pkg::CMD_UNLOCK);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ex_state_r <= eep_pkg::EX_IDLE;
            cnt_r <= '0;
            tgt_addr_r <= '0;
            tgt_data_r <= '0;
            lock_r <= 1'b1;
        end else if (ex_state_r != eep_pkg::EX_IDLE && !pwr_s) begin
            ex_state_r <= eep_pkg::EX_IDLE;
        end else begin
            case (ex_state_r)
                eep_pkg::EX_IDLE: begin
                    if (pop_valid) begin
                        tgt_addr_r <= pop_cmd.addr;
                        tgt_data_r <= (pop_cmd.kind == eep_pkg::CMD_ERASE
                                       || pop_cmd.kind == eep_pkg::CMD_ERASE_WHOLE_ARRAY)
                                      ? eep_pkg::ERASED_WORD : pop_cmd.data;
                        if (pop_cmd.kind == eep_pkg::CMD_LOCK) begin
                            lock_r <= 1'b1;
                        end else if (pop_cmd.kind == eep_pkg::CMD_UNLOCK) begin
                            lock_r <= 1'b0;
                        end else if (!lock_r && pwr_s) begin
                            case (pop_cmd.kind)
                                eep_pkg::CMD_ERASE_WHOLE_ARRAY: begin
                                    ex_state_r <= eep_pkg::EX_ERASE_WHOLE_ARRAY;
                                    cnt_r <= CNT_W'(ARRAY_ERASE_CYCLES - 1);
                                end
                                eep_pkg::CMD_WRITE_WHOLE_ARRAY: begin
                                    ex_state_r <= eep_pkg::EX_FILL_ERASE;
                                    cnt_r <= CNT_W'(ARRAY_ERASE_CYCLES - 1);
                                end
                                default: begin
                                    ex_state_r <= eep_pkg::EX_WORD;
                                    cnt_r <= CNT_W'(WORD_CYCLES - 1);
                                end
                            endcase
                        end
                    end
                end
                eep_pkg::EX_FILL_ERASE: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_zero) begin
                        ex_state_r <= eep_pkg::EX_FILL_PROG;
                        cnt_r <= CNT_W'(ARRAY_WRITE_CYCLES - ARRAY_ERASE_CYCLES - 1);
                    end
                end
                default: begin
                    // Runs on regardless of select
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_zero) begin
                        ex_state_r <= eep_pkg::EX_IDLE;
                    end
                end
            endcase
        end
    end

    // Word write erases at its first cycle, programs at its last
    always_comb begin
        wr_one = 1'b0;
        wr_all = 1'b0;
        wr_val = eep_pkg::ERASED_WORD;
        if (pwr_s) begin
            case (ex_state_r)
                eep_pkg::EX_WORD: begin
                    wr_one = cnt_zero || cnt_r == CNT_W'(WORD_CYCLES - 1);
                    wr_val = cnt_zero ? tgt_data_r : eep_pkg::ERASED_WORD;
                end
                eep_pkg::EX_ERASE_WHOLE_ARRAY, eep_pkg::EX_FILL_ERASE: wr_all = cnt_zero;
                eep_pkg::EX_FILL_PROG: begin
                    wr_all = cnt_zero;
                    wr_val = tgt_data_r;
                end
                default: wr_all = 1'b0;
            endcase
        end
    end

    for (genvar i = 0; i < eep_pkg::WORDS; i++) begin : g_word
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_r[i] <= eep_pkg::ERASED_WORD;
            end else if (wr_all || (wr_one && tgt_addr_r == 6'(i))) begin
                mem_r[i] <= wr_val;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status, standby and serial output
    // ----------------------------------------------------------------
    logic sel_prev_r, status_arm_r, prog_seen_r, start_prev_r, started_s_r;
    logic start_rise;
    assign start_rise = started_s_r && !start_prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev_r <= 1'b0;
            started_s_r <= 1'b0;
            start_prev_r <= 1'b0;
            status_arm_r <= 1'b0;
            prog_seen_r <= 1'b0;
            busy <= 1'b0;
            standby <= 1'b1;
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            sel_prev_r <= sel_s;
            started_s_r <= started_s && sel_s;
            start_prev_r <= started_s_r;
            busy <= (ex_state_r != eep_pkg::EX_IDLE) || (pop_valid && is_prog) || push_valid;
            if (ex_state_r != eep_pkg::EX_IDLE) begin
                prog_seen_r <= 1'b1;
            end else if (start_rise) begin
                prog_seen_r <= 1'b0;
            end
            if (!sel_s || start_rise) begin
                status_arm_r <= 1'b0;
            end else if (!sel_prev_r && (busy || prog_seen_r)) begin
                status_arm_r <= 1'b1;
            end
            standby <= !sel_s && !busy;
            serial_out_pin <= rd_act_s ? rd_bit_s : !busy;
            serial_out_oe <= sel_s && (rd_act_s || status_arm_r);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_array_erase_end;
        ex_state_r == eep_pkg::EX_FILL_ERASE && cnt_zero && pwr_s;
    endsequence
    sequence s_fill_start;
        ex_state_r == eep_pkg::EX_FILL_PROG ##0 !wr_all;
    endsequence

    a_write_whole_array_order: assert property (@(posedge clk) disable iff (!rst_n)
        s_array_erase_end |=> s_fill_start)
        else $error("array write did not follow array erase");
    a_lock_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        ex_state_r == eep_pkg::EX_IDLE && pop_valid && is_prog && lock_r
        |=> ex_state_r == eep_pkg::EX_IDLE)
        else $error("programming started while locked");
    a_power_guard: assert property (@(posedge clk) disable iff (!rst_n)
        !pwr_s |-> !wr_one && !wr_all)
        else $error("array written without good power");
    a_runs_on: assert property (@(posedge clk) disable iff (!rst_n)
        ex_state_r != eep_pkg::EX_IDLE && !cnt_zero && pwr_s && !sel_s
        |=> ex_state_r == $past(ex_state_r))
        else $error("programming cycle cut short");
    a_standby_wait: assert property (@(posedge clk) disable iff (!rst_n)
        standby |-> !$past(sel_s) && $past(ex_state_r) == eep_pkg::EX_IDLE)
        else $error("standby entered while programming");
    a_status_level: assert property (@(posedge clk) disable iff (!rst_n)
        serial_out_oe && !rd_act_s && $stable(busy) |=> serial_out_pin == !$past(busy))
        else $error("status output disagrees with busy");
    a_busy_shown: assert property (@(posedge clk) disable iff (!rst_n)
        ex_state_r != eep_pkg::EX_IDLE |=> busy)
        else $error("busy not shown during programming");
    a_word_erase: assert property (@(posedge clk) disable iff (!rst_n)
        ex_state_r == eep_pkg::EX_WORD && cnt_r == CNT_W'(WORD_CYCLES - 1) && pwr_s
        |=> mem_r[tgt_addr_r] == eep_pkg::ERASED_WORD)
        else $error("word not erased before programming");
    a_word_time: assert property (@(posedge clk) disable iff (!rst_n)
        ex_state_r == eep_pkg::EX_IDLE ##1 ex_state_r == eep_pkg::EX_WORD
        |-> cnt_r == CNT_W'(WORD_CYCLES - 1))
        else $error("word cycle length wrong");
    a_start_needs: assert property (@(posedge link_clk) disable iff (!link_arst_n)
        lk_state_r == eep_pkg::LK_WAIT && !serial_in_pin |=> lk_state_r == eep_pkg::LK_WAIT)
        else $error("start taken without data high");
    a_read_dummy: assert property (@(posedge link_clk) disable iff (!link_arst_n)
        lk_state_r == eep_pkg::LK_HDR && bit_cnt_r == 5'(eep_pkg::HDR_BITS - 1)
        && hdr_nxt[7:6] == eep_pkg::OP_READ |=> !rd_bit_r && rd_act_r)
        else $error("read lacks leading zero");
endmodule // eep_select_prog_ctrl

// [src/eep_pkg.sv]
// Behaviour
// - Storage is 64 words of 16 bits, addressed as whole words.
// - Select high means active; select low means deselected and standby.
// - A started programming cycle runs to its end unless supply power stops being good.
// - Deselection during programming enters standby only after the cycle ends.
// - Select low holds the instruction logic in reset, dropping partial instructions.
// - Erase and write are self-timed; a word write erases the word first.
// - Whole-array write first erases the whole array, then programs every word.
// - Ready/busy status is shown to the host while programming runs.
// - Programming is suppressed while supply power is not good.
// - Start is the first rising serial clock with select and data high.
// - Output is low while busy and high when ready, on reselection.
// - Power-up is locked; erase and write need an unlock first.
// - A read outputs one zero bit, then 16 data bits, MSB first.
package eep_pkg;
    localparam int WORDS = 64;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int HDR_BITS = 8;
    localparam int BUF_DEPTH = 2;
    localparam int CNT_W = 20;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

    // Opcode field and extended field of the header
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_WRITE_WHOLE_ARRAY = 2'h1;
    localparam logic [1:0] EXT_ERASE_WHOLE_ARRAY = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int WORD_TIME_NS = 2000000;
    localparam int ARRAY_ERASE_TIME_NS = 6000000;
    localparam int ARRAY_WRITE_TIME_NS = 15000000;
    localparam int WORD_CYCLES = WORD_TIME_NS / CLK_PERIOD_NS;
    localparam int ARRAY_ERASE_CYCLES = ARRAY_ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int ARRAY_WRITE_CYCLES = ARRAY_WRITE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        CMD_LOCK = 3'h0,
        CMD_UNLOCK = 3'h1,
        CMD_ERASE = 3'h2,
        CMD_ERASE_WHOLE_ARRAY = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_WRITE_WHOLE_ARRAY = 3'h5
    } eep_cmd_kind_t;

    typedef struct packed {
        eep_cmd_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eep_cmd_t;

    typedef enum logic [4:0] {
        LK_WAIT = 5'h01,
        LK_HDR = 5'h02,
        LK_DATA = 5'h04,
        LK_READ = 5'h08,
        LK_DONE = 5'h10
    } eep_link_state_t;

    typedef enum logic [4:0] {
        EX_IDLE = 5'h01,
        EX_WORD = 5'h02,
        EX_ERASE_WHOLE_ARRAY = 5'h04,
        EX_FILL_ERASE = 5'h08,
        EX_FILL_PROG = 5'h10
    } eep_exec_state_t;
endpackage

// [sim/eep_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the serial link
// ----------------------------------------
module eep_host_model (
    output logic link_clk,
    output logic select_line,
    output logic serial_in_pin,
    input wire logic serial_out_pin
);
    initial begin
        link_clk = 1'h0;
        select_line = 1'h0;
        serial_in_pin = 1'h0;
    end
    task automatic sel(input logic v);
        select_line = v;
    endtask
    // Clock runs only in a frame; rd keeps the last 17 output samples
    task automatic frame(input logic [26:0] b, input int n, output logic [16:0] rd);
        rd = '0;
        select_line = 1'h1;
        for (int i = 0; i < n; i++) begin
            serial_in_pin = b[26-i];
            #40;
            link_clk = 1'h1;
            #20;
            rd = {rd[15:0], serial_out_pin};
            #20;
            link_clk = 1'h0;
        end
        #60;
        rd = {rd[15:0], serial_out_pin};
        serial_in_pin = ~serial_in_pin;
        select_line = 1'h0;
        #300;
    endtask
endmodule // eep_host_model

// [sim/eep_select_prog_ctrl_tb_top.sv]
`timescale 1ns/1ps
module eep_select_prog_ctrl_tb_top;
    localparam int WC = 200;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic power_good = 1'h1;
    logic link_clk, select_line, serial_in_pin;
    logic serial_out_pin, serial_out_oe, standby, busy;
    logic host_do;
    logic [16:0] rd;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    always #10 clk = ~clk;
    eep_select_prog_ctrl #(.WORD_CYCLES(WC), .ARRAY_ERASE_CYCLES(600),
        .ARRAY_WRITE_CYCLES(1500)) i_dut (.clk(clk), .reset_n(reset_n),
        .link_clk(link_clk), .select_line(select_line), .serial_in_pin(serial_in_pin),
        .power_good(power_good), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .standby(standby), .busy(busy));
    eep_host_model i_host (.link_clk(link_clk), .select_line(select_line),
        .serial_in_pin(serial_in_pin), .serial_out_pin(host_do));
    // A released output shows the inverse of its last value to the host
    assign host_do = serial_out_oe ? serial_out_pin : !serial_out_pin;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        n = 0;
        while (busy !== 1'h0) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 5000) begin
                fail_count++;
                $display("BAD %0t busy stuck", $time);
                report_and_stop();
            end
        end
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [26:0] b, input int len);
        @(posedge clk);
        #1;
        i_host.frame(b, len, rd);
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        cmd({1'h1, eep_pkg::OP_WRITE, a, d, 2'h0}, 25);
    endtask
    task automatic ext(input logic [1:0] e, input logic [15:0] d);
        cmd({1'h1, eep_pkg::OP_EXT, e, 4'h0, d, 2'h0}, (e == eep_pkg::EXT_WRITE_WHOLE_ARRAY) ? 25 : 9);
    endtask
    // Two idle bits lead the start bit
    task automatic rdw(input logic [5:0] a, input logic [15:0] exp);
        cmd({2'h0, 1'h1, eep_pkg::OP_READ, a, 16'h0}, 27);
        chk(rd, {1'h0, exp});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        chk(17'({standby, busy, serial_out_oe}), 17'h4);
    endtask
    task automatic t_locked();
        wr(6'h05, 16'ha5c3);
        wait_idle();
        chk(17'(n), 17'h0);
        rdw(6'h05, 16'hffff);
    endtask
    task automatic t_status();
        ext(eep_pkg::EXT_UNLOCK, 16'h0);
        wr(6'h05, 16'ha5c3);
        i_host.sel(1'h1);
        repeat (5) @(posedge clk);
        #1;
        chk(17'({serial_out_oe, serial_out_pin, busy}), 17'h5);
        wait_idle();
        chk(17'({serial_out_oe, serial_out_pin}), 17'h3);
        chk(17'(n <= WC && n >= WC - 40), 17'h1);
        i_host.sel(1'h0);
        #300;
        rdw(6'h05, 16'ha5c3);
    endtask
    task automatic t_cut_standby();
        cmd({1'h1, eep_pkg::OP_WRITE, 6'h05, 18'h0}, 12);
        wait_idle();
        chk(17'(n), 17'h0);
        wr(6'h2a, 16'h1234);
        chk(17'({standby, busy}), 17'h1);
        wait_idle();
        chk(17'(standby), 17'h1);
        rdw(6'h2a, 16'h1234);
    endtask
    task automatic t_power();
        power_good = 1'h0;
        repeat (6) @(posedge clk);
        wr(6'h2a, 16'h0);
        wait_idle();
        chk(17'(n), 17'h0);
        power_good = 1'h1;
        repeat (6) @(posedge clk);
        ext(eep_pkg::EXT_UNLOCK, 16'h0);
        rdw(6'h2a, 16'h1234);
    endtask
    task automatic t_array();
        cmd({1'h1, eep_pkg::OP_ERASE, 6'h2a, 18'h0}, 9);
        wait_idle();
        rdw(6'h2a, 16'hffff);
        ext(eep_pkg::EXT_WRITE_WHOLE_ARRAY, 16'h3c3c);
        wait_idle();
        chk(17'(n > 600), 17'h1);
        rdw(6'h00, 16'h3c3c);
        rdw(6'h3f, 16'h3c3c);
        ext(eep_pkg::EXT_ERASE_WHOLE_ARRAY, 16'h0);
        wait_idle();
        rdw(6'h3f, 16'hffff);
        ext(eep_pkg::EXT_LOCK, 16'h0);
        wr(6'h00, 16'h0);
        wait_idle();
        chk(17'(n), 17'h0);
        rdw(6'h00, 16'hffff);
    endtask
    initial begin
        t_reset();
        t_locked();
        t_status();
        t_cut_standby();
        t_power();
        t_array();
        report_and_stop();
    end
endmodule // eep_select_prog_ctrl_tb_top
